/* verilog/flb_pkg.sv */
/*
  package of the fast-mode / protect / status host controller: pin widths,
  command codes, status bit positions, user operation codes and timing counts.
  assumes a 40 MHz controller clock and a 16-bit word-mode flash data bus.
*/
`default_nettype none
package flb_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETUP_NS = 25;
  localparam int WR_LOW_NS = 50;
  localparam int RD_ACCESS_NS = 70;
  localparam int SYNC_STAGES = 2;
  localparam int GAP_NS = 25;
  localparam int PROTECT_US = 250;
  localparam int MAX_PROTECT_TRIES = 25;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC = ns_to_cyc(SETUP_NS);
  localparam int WR_LOW_CYC = ns_to_cyc(WR_LOW_NS);
  localparam int RD_LOW_CYC = ns_to_cyc(RD_ACCESS_NS) + SYNC_STAGES;
  localparam int GAP_CYC = ns_to_cyc(GAP_NS);
  localparam int PROTECT_CYC = ns_to_cyc(PROTECT_US * 1000);

  // ==========================================================
  // pin widths and fields
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int SECT_LSB = 12;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE1_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int WINDOW_BIT = 3;
  localparam int TOGGLE2_BIT = 2;
  localparam int VERIFY_BIT = 0;
  localparam logic [SECT_LSB-1:0] PROT_SEL_LOW = 12'h002;

  // ==========================================================
  // flash command codes and unlock addresses
  localparam logic [7:0] CODE_PROG = 8'ha0;
  localparam logic [7:0] CODE_PROTECT = 8'h60;
  localparam logic [7:0] CODE_VERIFY = 8'h40;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_FAST_ENTER = 8'h20;
  localparam logic [7:0] CODE_FAST_EXIT1 = 8'h90;
  localparam logic [7:0] CODE_FAST_EXIT2 = 8'hf0;
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002aa;

  // ==========================================================
  // user operation codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_FAST_ENTER = 3'h1;
  localparam logic [2:0] OP_FAST_PROG = 3'h2;
  localparam logic [2:0] OP_FAST_EXIT = 3'h3;
  localparam logic [2:0] OP_PROTECT = 3'h4;
  localparam logic [2:0] OP_RESUME = 3'h5;
  localparam logic [2:0] OP_POLL = 3'h6;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic last;
  } flb_step_t;
endpackage
`default_nettype wire

/* verilog/flb_cycle.sv */
/*
  one asynchronous flash bus cycle (write or read) built from the controller
  clock; chip enable and output enable return high between cycles.
  assumes dq_i comes straight from the pins and resynchronises it here.
*/
`timescale 1ns/1ps
`default_nettype none
module flb_cycle
  import flb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic go,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // flash pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [ADDR_W-1:0] addr_o,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe
);
  // ==========================================================
  // state
  typedef enum logic [3:0] {
    CY_IDLE = 4'b0001,
    CY_SETUP = 4'b0010,
    CY_STROBE = 4'b0100,
    CY_HOLD = 4'b1000
  } flb_cy_t;

  typedef struct packed {
    flb_cy_t st;
    logic [3:0] cnt;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
    logic wr;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
  } flb_cy_state_t;

  flb_cy_state_t q_ff;
  flb_cy_state_t nxt_q;

  // ==========================================================
  // next state
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    nxt_q.s1 = dq_i;
    nxt_q.s2 = q_ff.s1;
    case (q_ff.st)
      CY_IDLE: begin
        if (go) begin
          nxt_q.addr = addr;
          nxt_q.dq_o = wdata;
          nxt_q.wr = wr;
          nxt_q.dq_oe = wr;
          nxt_q.ce_n = 1'b0;
          nxt_q.cnt = 4'(SETUP_CYC);
          nxt_q.st = CY_SETUP;
        end
      end
      CY_SETUP: begin
        if (q_ff.cnt == 4'h1) begin
          if (q_ff.wr) begin
            nxt_q.we_n = 1'b0;
            nxt_q.cnt = 4'(WR_LOW_CYC);
          end else begin
            nxt_q.oe_n = 1'b0;
            nxt_q.cnt = 4'(RD_LOW_CYC);
          end
          nxt_q.st = CY_STROBE;
        end else begin
          nxt_q.cnt = q_ff.cnt - 4'h1;
        end
      end
      CY_STROBE: begin
        if (q_ff.cnt == 4'h1) begin
          nxt_q.we_n = 1'b1;
          nxt_q.oe_n = 1'b1;
          if (!q_ff.wr) begin
            nxt_q.rdata = q_ff.s2;
          end
          nxt_q.cnt = 4'(GAP_CYC);
          nxt_q.st = CY_HOLD;
        end else begin
          nxt_q.cnt = q_ff.cnt - 4'h1;
        end
      end
      CY_HOLD: begin
        if (q_ff.cnt == 4'h1) begin
          // chip enable high before any address change
          nxt_q.ce_n = 1'b1;
          nxt_q.dq_oe = 1'b0;
          nxt_q.done = 1'b1;
          nxt_q.st = CY_IDLE;
        end else begin
          nxt_q.cnt = q_ff.cnt - 4'h1;
        end
      end
      default: nxt_q.st = CY_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_ff <= '{st: CY_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign done = q_ff.done;
  assign rdata = q_ff.rdata;
  assign ce_n = q_ff.ce_n;
  assign oe_n = q_ff.oe_n;
  assign we_n = q_ff.we_n;
  assign addr_o = q_ff.addr;
  assign dq_o = q_ff.dq_o;
  assign dq_oe = q_ff.dq_oe;
endmodule
`default_nettype wire

/* verilog/flb_host.sv */
/*
  host controller for a dual-bank parallel flash: fast mode entry, fast
  programming and exit, extended sector protect with verify, erase resume,
  plain reads and toggle-bit status polling.
  assumes one user request at a time and a flash wired to the pin ports.
*/
`timescale 1ns/1ps
`default_nettype none
module flb_host
  import flb_pkg::*;
#(
  parameter int PROTECT_WAIT_CYC = PROTECT_CYC
)(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // user command port
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_OP,
  input wire logic [ADDR_W-1:0] CMD_ADDR,
  input wire logic [DATA_W-1:0] CMD_DATA,
  output logic CMD_READY,
  // user response port
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_DATA,
  output logic RSP_FAIL,
  output logic RSP_BUSY,
  output logic RSP_REFUSED,
  output logic FAST_MODE,
  // flash pins
  output logic FLASH_CE_N,
  output logic FLASH_OE_N,
  output logic FLASH_WE_N,
  output logic [ADDR_W-1:0] FLASH_ADDR,
  input wire logic [DATA_W-1:0] FLASH_DQ_I,
  output logic [DATA_W-1:0] FLASH_DQ_O,
  output logic FLASH_DQ_OE,
  output logic FLASH_RESET_N,
  output logic FLASH_RESET_HV
);
  // ==========================================================
  // state
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_GO = 5'b00010,
    S_WAIT = 5'b00100,
    S_PWAIT = 5'b01000,
    S_END = 5'b10000
  } flb_st_t;

  typedef struct packed {
    flb_st_t st;
    logic [2:0] op;
    logic [1:0] idx;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic fast;
    logic hv;
    logic reset_n;
    logic [4:0] tries;
    logic [23:0] wcnt;
    logic [DATA_W-1:0] rd0;
    logic go;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic rsp_fail;
    logic rsp_busy;
    logic rsp_refused;
  } flb_host_state_t;

  flb_host_state_t q_ff;
  flb_host_state_t nxt_q;
  flb_step_t step;
  logic cy_done;
  logic [DATA_W-1:0] cy_rdata;
  logic tog;

  // ==========================================================
  // helpers
  function automatic logic [ADDR_W-1:0] prot_addr(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:SECT_LSB], PROT_SEL_LOW};
  endfunction

  function automatic logic [DATA_W-1:0] code(input logic [7:0] c);
    return {8'h00, c};
  endfunction

  function automatic flb_step_t step_of(input logic [2:0] op, input logic [1:0] idx,
                                        input logic [ADDR_W-1:0] a,
                                        input logic [DATA_W-1:0] d);
    flb_step_t s;
    s.wr = 1'b1;
    s.addr = a;
    s.data = 16'h0000;
    s.last = 1'b1;
    case (op)
      OP_READ: begin
        s.wr = 1'b0;
      end
      OP_FAST_ENTER: begin
        s.addr = (idx == 2'h1) ? UNLOCK2_ADDR : UNLOCK1_ADDR;
        s.data = code(idx == 2'h0 ? CODE_UNLOCK1 :
                      (idx == 2'h1 ? CODE_UNLOCK2 : CODE_FAST_ENTER));
        s.last = (idx == 2'h2);
      end
      OP_FAST_EXIT: begin
        s.data = code(idx == 2'h0 ? CODE_FAST_EXIT1 : CODE_FAST_EXIT2);
        s.last = (idx == 2'h1);
      end
      OP_FAST_PROG: begin
        s.data = (idx == 2'h0) ? code(CODE_PROG) : d;
        s.last = (idx == 2'h1);
      end
      OP_RESUME: begin
        s.data = code(CODE_RESUME);
      end
      OP_PROTECT: begin
        s.addr = (idx == 2'h0) ? a : prot_addr(a);
        s.data = code(idx[1] ? CODE_VERIFY : CODE_PROTECT);
        s.wr = (idx != 2'h3);
        s.last = idx[0];
      end
      OP_POLL: begin
        s.wr = 1'b0;
        s.last = idx[0];
      end
      default: begin
        s.wr = 1'b0;
      end
    endcase
    return s;
  endfunction

  // ==========================================================
  // bus cycle engine
  flb_cycle u_cycle (
    .clk(CLK),
    .rst_n(RSTN),
    .go(q_ff.go),
    .wr(step.wr),
    .addr(step.addr),
    .wdata(step.data),
    .done(cy_done),
    .rdata(cy_rdata),
    .ce_n(FLASH_CE_N),
    .oe_n(FLASH_OE_N),
    .we_n(FLASH_WE_N),
    .addr_o(FLASH_ADDR),
    .dq_i(FLASH_DQ_I),
    .dq_o(FLASH_DQ_O),
    .dq_oe(FLASH_DQ_OE)
  );

  assign step = step_of(q_ff.op, q_ff.idx, q_ff.addr, q_ff.data);
  // toggle bit one flips between two successive reads while busy
  assign tog = q_ff.rd0[TOGGLE1_BIT] ^ cy_rdata[TOGGLE1_BIT];

  // ==========================================================
  // sequencer
  always_comb begin
    nxt_q = q_ff;
    nxt_q.go = 1'b0;
    nxt_q.rsp_valid = 1'b0;
    nxt_q.reset_n = 1'b1;
    case (q_ff.st)
      S_IDLE: begin
        nxt_q.ready = 1'b1;
        if (CMD_VALID && q_ff.ready) begin
          nxt_q.ready = 1'b0;
          nxt_q.op = CMD_OP;
          nxt_q.addr = CMD_ADDR;
          nxt_q.data = CMD_DATA;
          nxt_q.idx = 2'h0;
          nxt_q.tries = 5'h00;
          nxt_q.rsp_fail = 1'b0;
          nxt_q.rsp_busy = 1'b0;
          nxt_q.rsp_refused = 1'b0;
          nxt_q.st = S_GO;
          if (CMD_OP > OP_POLL || (CMD_OP == OP_FAST_PROG && !q_ff.fast) ||
              (CMD_OP == OP_FAST_ENTER && q_ff.fast)) begin
            nxt_q.rsp_refused = 1'b1;
            nxt_q.st = S_END;
          end else if (CMD_OP == OP_PROTECT) begin
            nxt_q.hv = 1'b1;
          end
        end
      end
      S_GO: begin
        nxt_q.go = 1'b1;
        nxt_q.st = S_WAIT;
      end
      S_WAIT: begin
        if (cy_done) begin
          nxt_q.rsp_data = cy_rdata;
          if (!q_ff.idx[0]) begin
            nxt_q.rd0 = cy_rdata;
          end
          if (!step.last) begin
            nxt_q.idx = 2'(q_ff.idx + 2'h1);
            nxt_q.st = S_GO;
          end else begin
            nxt_q.st = S_END;
            case (q_ff.op)
              OP_FAST_ENTER: nxt_q.fast = 1'b1;
              OP_FAST_EXIT: nxt_q.fast = 1'b0;
              OP_PROTECT: begin
                if (q_ff.idx == 2'h1) begin
                  nxt_q.wcnt = 24'(PROTECT_WAIT_CYC);
                  nxt_q.st = S_PWAIT;
                end else if (!cy_rdata[VERIFY_BIT]) begin
                  if (q_ff.tries == 5'(MAX_PROTECT_TRIES - 1)) begin
                    nxt_q.rsp_fail = 1'b1;
                  end else begin
                    nxt_q.tries = q_ff.tries + 5'h01;
                    nxt_q.idx = 2'h1;
                    nxt_q.st = S_GO;
                  end
                end
              end
              OP_POLL: begin
                if (q_ff.idx == 2'h1) begin
                  if (tog && cy_rdata[FAIL_BIT]) begin
                    nxt_q.idx = 2'h2;
                    nxt_q.st = S_GO;
                  end else begin
                    nxt_q.rsp_busy = tog;
                  end
                end else begin
                  nxt_q.rsp_fail = tog;
                end
              end
              default: nxt_q.st = S_END;
            endcase
          end
        end
      end
      S_PWAIT: begin
        if (q_ff.wcnt <= 24'h000001) begin
          nxt_q.idx = 2'h2;
          nxt_q.st = S_GO;
        end else begin
          nxt_q.wcnt = q_ff.wcnt - 24'h000001;
        end
      end
      S_END: begin
        nxt_q.hv = 1'b0;
        nxt_q.rsp_valid = 1'b1;
        nxt_q.ready = 1'b1;
        nxt_q.st = S_IDLE;
      end
      default: nxt_q.st = S_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      q_ff <= '{st: S_IDLE, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign CMD_READY = q_ff.ready;
  assign RSP_VALID = q_ff.rsp_valid;
  assign RSP_DATA = q_ff.rsp_data;
  assign RSP_FAIL = q_ff.rsp_fail;
  assign RSP_BUSY = q_ff.rsp_busy;
  assign RSP_REFUSED = q_ff.rsp_refused;
  assign FAST_MODE = q_ff.fast;
  assign FLASH_RESET_N = q_ff.reset_n;
  assign FLASH_RESET_HV = q_ff.hv;
endmodule
`default_nettype wire

/* verification/flb_host_properties.sv */
/*
  checker of flb_host pin strobes and user port answers.
  assumes it is bound into every flb_host instance.
*/
`timescale 1ns/1ps
`default_nettype none
module flb_host_chk
  import flb_pkg::*;
#(
  parameter int PROTECT_WAIT_CYC = PROTECT_CYC
)(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // user port
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_OP,
  input wire logic CMD_READY,
  input wire logic RSP_VALID,
  input wire logic RSP_REFUSED,
  input wire logic FAST_MODE,
  // flash pins
  input wire logic FLASH_CE_N,
  input wire logic FLASH_OE_N,
  input wire logic FLASH_WE_N,
  input wire logic [ADDR_W-1:0] FLASH_ADDR,
  input wire logic [DATA_W-1:0] FLASH_DQ_O,
  input wire logic FLASH_DQ_OE,
  input wire logic FLASH_RESET_HV
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire take = CMD_VALID && CMD_READY;
  // ==========================================================
  // pulse shapes
  sequence s_we_low; !FLASH_WE_N [*2] ##1 FLASH_WE_N; endsequence
  sequence s_oe_low; !FLASH_OE_N [*5] ##1 FLASH_OE_N; endsequence
  sequence s_refuse; FLASH_CE_N [*2] ##1 (RSP_VALID && RSP_REFUSED); endsequence
  // ==========================================================
  // properties
  property p_we_pulse; $fell(FLASH_WE_N) |-> s_we_low; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width");
  property p_oe_pulse; $fell(FLASH_OE_N) |-> s_oe_low; endproperty
  a_oe_pulse: assert property (p_oe_pulse) else $error("read strobe width");
  property p_we_in_ce; !FLASH_WE_N |-> !FLASH_CE_N && FLASH_OE_N && FLASH_DQ_OE; endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("write framing");
  property p_oe_in_ce; !FLASH_OE_N |-> !FLASH_CE_N && FLASH_WE_N && !FLASH_DQ_OE; endproperty
  a_oe_in_ce: assert property (p_oe_in_ce) else $error("read framing");
  property p_addr_hold; !FLASH_CE_N && !$past(FLASH_CE_N) |-> $stable(FLASH_ADDR); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_no_erase;
    !FLASH_WE_N && FLASH_ADDR == UNLOCK1_ADDR |-> FLASH_DQ_O[7:0] != 8'h80;
  endproperty
  a_no_erase: assert property (p_no_erase) else $error("erase code sent");
  property p_refused; take && CMD_OP == OP_FAST_PROG && !FAST_MODE |-> s_refuse; endproperty
  a_refused: assert property (p_refused) else $error("program not refused");
  property p_fast_hold; take && FAST_MODE && CMD_OP != OP_FAST_EXIT |=> FAST_MODE; endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("fast mode lost");
  property p_verify_addr;
    FLASH_RESET_HV && !FLASH_WE_N && FLASH_DQ_O[7:0] == CODE_VERIFY
      |-> FLASH_ADDR[SECT_LSB-1:0] == PROT_SEL_LOW;
  endproperty
  a_verify_addr: assert property (p_verify_addr) else $error("verify select");
  property p_hv_end; RSP_VALID |-> !FLASH_RESET_HV; endproperty
  a_hv_end: assert property (p_hv_end) else $error("high voltage left on");
endmodule
bind flb_host flb_host_chk #(.PROTECT_WAIT_CYC(PROTECT_WAIT_CYC)) u_chk (
  .CLK(CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
  .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_REFUSED(RSP_REFUSED),
  .FAST_MODE(FAST_MODE), .FLASH_CE_N(FLASH_CE_N), .FLASH_OE_N(FLASH_OE_N),
  .FLASH_WE_N(FLASH_WE_N), .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_O(FLASH_DQ_O),
  .FLASH_DQ_OE(FLASH_DQ_OE), .FLASH_RESET_HV(FLASH_RESET_HV)
);
`default_nettype wire

/* verification/flb_flash_model.sv */
/*
  behavioural dual-bank flash: fast mode, fast program, protect, status reads.
  assumes flb_host strobes; the merged data bus leaves on dq.
*/
`timescale 1ns/1ps
`default_nettype none
module flb_flash_model
  import flb_pkg::*;
#(
  parameter int PROG_NS = 3000,
  parameter int PROT_TRIES = 2,
  parameter logic [ADDR_W-1:0] FAIL_ADDR = 19'h00bad
)(
  // strobes and address
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic reset_n,
  input wire logic reset_hv,
  // data bus
  input wire logic [DATA_W-1:0] host_dq,
  input wire logic host_oe,
  output logic [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  bit prot [logic [6:0]];
  logic fast, busy, pmode, failed = 1'h0, verify = 1'h0, tog1 = 1'h0;
  logic [1:0] unl;
  logic [7:0] last, c;
  logic [ADDR_W-1:0] b_addr;
  logic [DATA_W-1:0] b_data, out = 16'hffff;
  int tries = 0;
  int bad_cmds = 0;
  int resumes = 0;
  wire [6:0] sect = addr[ADDR_W-1:SECT_LSB];
  task automatic start_prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bit p;
    p = prot.exists(a[ADDR_W-1:SECT_LSB]) != 0;
    busy = 1'h1;
    b_addr = a;
    b_data = d;
    failed = (a == FAIL_ADDR);
    if (!failed) fork
      begin
        #(p ? 2000 : PROG_NS);
        if (!p) mem[a] = d;
        busy = 1'h0;
      end
    join_none
  endtask
  // ==========================================================
  // writes
  always @(posedge we_n) begin
    if (!ce_n) begin
      c = host_dq[7:0];
      verify = 1'h0;
      if (last == CODE_PROG && fast) begin
        start_prog(addr, host_dq);
        c = 8'h00;
      end else if (last == CODE_FAST_EXIT1 && c == CODE_FAST_EXIT2) begin
        fast = 1'h0;
        busy = 1'h0;
      end else if (reset_hv && c == CODE_PROTECT) begin
        if (pmode && addr[SECT_LSB-1:0] == PROT_SEL_LOW) tries++;
        if (tries >= PROT_TRIES) prot[sect] = 1'h1;
        pmode = 1'h1;
      end else if (reset_hv && pmode && c == CODE_VERIFY) begin
        verify = 1'h1;
      end else if (fast && c == 8'h80) begin
        bad_cmds++;
      end else if (c == CODE_RESUME) begin
        resumes++;
      end
      if (unl == 2'h2 && c == CODE_FAST_ENTER && addr == UNLOCK1_ADDR) fast = 1'h1;
      if (unl == 2'h1 && c == CODE_UNLOCK2 && addr == UNLOCK2_ADDR) unl = 2'h2;
      else unl = (c == CODE_UNLOCK1 && addr == UNLOCK1_ADDR) ? 2'h1 : 2'h0;
      last = c;
    end
  end
  // ==========================================================
  // reads and bus
  always @(negedge oe_n) begin
    if (!ce_n) begin
      if (verify) out = {15'h0000, prot.exists(sect) != 0};
      else if (busy && addr[ADDR_W-1] == b_addr[ADDR_W-1]) begin
        tog1 = ~tog1;
        out = {8'h00, ~b_data[7], tog1, failed, 5'h04};
      end else out = mem.exists(addr) ? mem[addr] : 16'hffff;
    end
  end
  assign dq = host_oe ? host_dq : (!ce_n && !oe_n) ? out : ~out;
  always @(negedge reset_n) begin
    fast = 1'h0;
    busy = 1'h0;
    pmode = 1'h0;
    unl = 2'h0;
    last = 8'h00;
  end
  always @(negedge reset_hv) pmode = 1'h0;
endmodule
`default_nettype wire

/* verification/flb_host_tb.sv */
/*
  self-checking bench of flb_host against the behavioural flash.
  assumes flb_pkg, flb_host, flb_flash_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module flb_host_tb
  import flb_pkg::*;
;
  localparam logic [ADDR_W-1:0] A_PROG = 19'h00100;
  localparam logic [ADDR_W-1:0] A_SECT = 19'h23000;
  localparam logic [ADDR_W-1:0] A_FAIL = 19'h00bad;
  localparam logic [DATA_W-1:0] D_PROG = 16'h1234;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic cmd_valid = 1'h0;
  logic [2:0] cmd_op = 3'h0;
  logic [ADDR_W-1:0] cmd_addr = 19'h00000;
  logic [DATA_W-1:0] cmd_data = 16'h0000;
  logic cmd_ready, rsp_valid, rsp_fail, rsp_busy, rsp_refused, fast_mode;
  logic ce_n, oe_n, we_n, dq_oe, f_reset_n, f_reset_hv;
  logic [ADDR_W-1:0] f_addr;
  logic [DATA_W-1:0] rsp_data, dq_o, dq_bus;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  flb_host #(.PROTECT_WAIT_CYC(8)) DUT (
    .CLK(clk), .RSTN(rstn), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_FAIL(rsp_fail),
    .RSP_BUSY(rsp_busy), .RSP_REFUSED(rsp_refused), .FAST_MODE(fast_mode),
    .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .FLASH_ADDR(f_addr),
    .FLASH_DQ_I(dq_bus), .FLASH_DQ_O(dq_o), .FLASH_DQ_OE(dq_oe),
    .FLASH_RESET_N(f_reset_n), .FLASH_RESET_HV(f_reset_hv)
  );
  flb_flash_model u_flash (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .reset_n(f_reset_n),
    .reset_hv(f_reset_hv), .host_dq(dq_o), .host_oe(dq_oe), .dq(dq_bus)
  );
  // ==========================================================
  // tasks
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_op(input logic [2:0] op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    do @(posedge clk); while (cmd_ready !== 1'h1);
    cmd_valid <= 1'h0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp_valid !== 1'h1 && k < 2000);
    if (rsp_valid !== 1'h1) err_count++;
  endtask
  task automatic poll_idle(input logic [ADDR_W-1:0] a);
    int k;
    k = 0;
    do begin
      do_op(OP_POLL, a, 16'h0000);
      k++;
    end while (rsp_busy === 1'h1 && k < 20);
    if (rsp_busy === 1'h1) err_count++;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // sequence of tests
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    `CHK("flash reset", 1'h1, f_reset_n)
    do_op(OP_FAST_PROG, A_PROG, D_PROG);
    `CHK("prog outside fast", 1'h1, rsp_refused)
    do_op(3'h7, A_PROG, 16'h0000);
    `CHK("op seven", 1'h1, rsp_refused)
    do_op(OP_FAST_ENTER, A_PROG, 16'h0000);
    `CHK("fast mode", 1'h1, fast_mode)
    do_op(OP_FAST_ENTER, A_PROG, 16'h0000);
    `CHK("second enter", 1'h1, rsp_refused)
    do_op(OP_FAST_PROG, A_PROG, D_PROG);
    `CHK("fast prog", 1'h0, rsp_refused)
    do_op(OP_READ, 19'h40100, 16'h0000);
    `CHK("other bank", 16'hffff, rsp_data)
    do_op(OP_POLL, A_PROG, 16'h0000);
    `CHK("busy", 1'h1, rsp_busy)
    `CHK("poll bit", ~D_PROG[7], rsp_data[POLL_BIT])
    `CHK("status", 3'h1, {rsp_data[FAIL_BIT], rsp_data[WINDOW_BIT], rsp_data[TOGGLE2_BIT]})
    poll_idle(A_PROG);
    `CHK("idle", 1'h0, rsp_busy)
    do_op(OP_READ, A_PROG, 16'h0000);
    `CHK("array", D_PROG, rsp_data)
    do_op(OP_PROTECT, A_SECT, 16'h0000);
    `CHK("verify bit", 1'h1, rsp_data[VERIFY_BIT])
    `CHK("protect ok", 1'h0, rsp_fail)
    `CHK("tries", 2, u_flash.tries)
    `CHK("high voltage", 1'h0, f_reset_hv)
    do_op(OP_FAST_PROG, A_SECT, 16'h0000);
    poll_idle(A_SECT);
    do_op(OP_READ, A_SECT, 16'h0000);
    `CHK("protected data", 16'hffff, rsp_data)
    do_op(OP_FAST_PROG, A_FAIL, 16'h00ff);
    do_op(OP_POLL, A_FAIL, 16'h0000);
    `CHK("fail", 1'h1, rsp_fail)
    `CHK("fail bit", 1'h1, rsp_data[FAIL_BIT])
    do_op(OP_FAST_EXIT, A_FAIL, 16'h0000);
    `CHK("fast left", 1'h0, fast_mode)
    `CHK("flash fast", 1'h0, u_flash.fast)
    do_op(OP_FAST_PROG, A_PROG, D_PROG);
    `CHK("prog after exit", 1'h1, rsp_refused)
    do_op(OP_RESUME, A_SECT, 16'h0000);
    `CHK("resume", 1'h0, rsp_refused)
    `CHK("resume code", 1, u_flash.resumes)
    `CHK("erase codes", 0, u_flash.bad_cmds)
    report_and_stop();
  end
endmodule
`default_nettype wire
